// ===== verilog/lasr_pkg.sv
package lasr_pkg;

	localparam int LASR_NUM_LANES = 3;
	localparam int LASR_REG_W = 16;
	localparam int LASR_ADDR_W = 12;
	localparam int LASR_ERR_W = 8;

	// register word indices; the byte address is four times the index
	localparam logic [9:0] LASR_IDX_LANE3 = 10'h067;
	localparam logic [9:0] LASR_IDX_LANE4 = 10'h068;
	localparam logic [9:0] LASR_IDX_LANE5 = 10'h069;
	localparam logic [9:0] LASR_IDX_MASK_BASE = 10'h080;

	// status field positions
	localparam int LASR_ERR_LSB = 8;
	localparam int LASR_BIT_MF_ALIGN = 15;
	localparam int LASR_BIT_FR_ALIGN = 14;
	localparam int LASR_BIT_LINK_CFG = 13;
	localparam int LASR_BIT_EB_OVF = 12;
	localparam int LASR_BIT_EB_MATCH = 11;
	localparam int LASR_BIT_CODE_SYNC = 10;
	localparam int LASR_BIT_NOT_TABLE = 9;
	localparam int LASR_BIT_DISP = 8;
	localparam int LASR_RSV_MSB = 7;
	localparam int LASR_RSV_LSB = 4;
	localparam int LASR_BIT_WR_ERR = 3;
	localparam int LASR_BIT_FULL = 2;
	localparam int LASR_BIT_RD_ERR = 1;
	localparam int LASR_BIT_EMPTY = 0;

	localparam logic [15:0] LASR_STAT_RST = 16'h0000;
	localparam logic [15:0] LASR_MASK_RST = 16'h0000;
	localparam logic [31:0] LASR_RDATA_RST = 32'h0000_0000;

	// ahb transfer types and response
	localparam logic [1:0] LASR_HTRANS_IDLE = 2'h0;
	localparam logic [1:0] LASR_HTRANS_NONSEQ = 2'h2;
	localparam logic LASR_HRESP_OKAY = 1'b0;

	// one lane's detector outputs; lane_err bit 7 is multiframe alignment, bit 0 disparity
	typedef struct packed {
		logic [7:0] lane_err;
		logic fifo_wr_req;
		logic fifo_rd_req;
		logic fifo_full;
		logic fifo_empty;
	} lasr_lane_evt_t;

endpackage

// ===== verilog/lasr_lane_stat.sv
`timescale 1ns/100ps
module lasr_lane_stat
	import lasr_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire lasr_lane_evt_t evt_i,
	input wire logic [15:0] clr_i,
	output logic [15:0] stat_o,
	output logic [15:0] set_o
);

	logic [15:0] stat_ff;
	logic [15:0] nxt_stat;
	logic [15:0] set_v;

	always_comb begin
		set_v = LASR_STAT_RST;
		set_v[LASR_BIT_MF_ALIGN:LASR_ERR_LSB] = evt_i.lane_err;
		set_v[LASR_BIT_WR_ERR] = evt_i.fifo_wr_req & evt_i.fifo_full;
		set_v[LASR_BIT_FULL] = evt_i.fifo_full;
		set_v[LASR_BIT_RD_ERR] = evt_i.fifo_rd_req & evt_i.fifo_empty;
		set_v[LASR_BIT_EMPTY] = evt_i.fifo_empty;
	end

	// set wins over a clear in the same cycle so no event is lost
	assign nxt_stat = (stat_ff & ~clr_i) | set_v;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			stat_ff <= LASR_STAT_RST;
		end else begin
			stat_ff <= nxt_stat;
		end
	end

	assign stat_o = stat_ff;
	assign set_o = set_v;

endmodule // lasr_lane_stat

// ===== verilog/lasr_regs.sv
// Local design decision: register access over AHB-Lite.
`timescale 1ns/100ps
module lasr_regs
	import lasr_pkg::*;
(
	input wire logic CORE_CLK_I,
	input wire logic RST_N_I,
	input wire logic HSEL_I,
	input wire logic [11:0] HADDR_I,
	input wire logic [1:0] HTRANS_I,
	input wire logic HWRITE_I,
	input wire logic [2:0] HSIZE_I,
	input wire logic [31:0] HWDATA_I,
	input wire logic HREADY_I,
	output logic HREADYOUT_O,
	output logic HRESP_O,
	output logic [31:0] HRDATA_O,
	input wire lasr_lane_evt_t [2:0] LANE_EVT_I,
	output logic IRQ_O
);

	logic [15:0] stat [LASR_NUM_LANES];
	logic [15:0] set_v [LASR_NUM_LANES];
	logic [15:0] clr [LASR_NUM_LANES];
	logic [15:0] keep [LASR_NUM_LANES];
	logic [15:0] drop [LASR_NUM_LANES];
	logic [15:0] mask_ff [LASR_NUM_LANES];
	logic [LASR_NUM_LANES-1:0] lane_irq;
	logic [LASR_NUM_LANES-1:0] rd_stat_hit;
	logic [LASR_NUM_LANES-1:0] wr_stat_hit;
	logic [LASR_NUM_LANES-1:0] wr_mask_hit;
	logic [LASR_NUM_LANES-1:0] ap_stat_hit;
	logic [LASR_NUM_LANES-1:0] ap_mask_hit;
	logic [9:0] ap_idx;
	logic ap_take;
	logic ap_read;
	logic wr_pend_ff;
	logic [9:0] wr_idx_ff;
	logic [31:0] hrdata_ff;
	logic [31:0] nxt_hrdata;
	logic irq_ff;

	// address phase; the size is not checked, only whole-word transfers are supported
	assign ap_take = HSEL_I & HTRANS_I[1] & HREADY_I;
	assign ap_read = ap_take & ~HWRITE_I;
	assign ap_idx = HADDR_I[11:2];

	// no wait states and no error answers: every access completes with OKAY
	assign HREADYOUT_O = 1'b1;
	assign HRESP_O = LASR_HRESP_OKAY;

	always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			wr_pend_ff <= 1'b0;
			wr_idx_ff <= '0;
		end else begin
			wr_pend_ff <= ap_take & HWRITE_I;
			if (ap_take) begin
				wr_idx_ff <= ap_idx;
			end
		end
	end

	genvar lane;
	generate
		for (lane = 0; lane < LASR_NUM_LANES; lane++) begin : g_lane
			// lanes 3..5 occupy consecutive word indices
			assign ap_stat_hit[lane] = (ap_idx == LASR_IDX_LANE3 + 10'(lane));
			assign ap_mask_hit[lane] = (ap_idx == LASR_IDX_MASK_BASE + 10'(lane));
			assign wr_stat_hit[lane] = wr_pend_ff & (wr_idx_ff == LASR_IDX_LANE3 + 10'(lane));
			assign wr_mask_hit[lane] = wr_pend_ff & (wr_idx_ff == LASR_IDX_MASK_BASE + 10'(lane));
			assign rd_stat_hit[lane] = ap_read & ap_stat_hit[lane];

			// write-one-to-clear; reserved bits never hold anything
			assign clr[lane] = wr_stat_hit[lane] ? HWDATA_I[15:0] : LASR_STAT_RST;

			lasr_lane_stat u_stat (
				.clk_i(CORE_CLK_I),
				.rst_n_i(RST_N_I),
				.evt_i(LANE_EVT_I[lane]),
				.clr_i(clr[lane]),
				.stat_o(stat[lane]),
				.set_o(set_v[lane])
			);

			always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
				if (!RST_N_I) begin
					mask_ff[lane] <= LASR_MASK_RST;
				end else if (wr_mask_hit[lane]) begin
					mask_ff[lane] <= HWDATA_I[15:0];
				end
			end

			assign lane_irq[lane] = |(stat[lane] & mask_ff[lane]);
			assign keep[lane] = stat[lane] & ~clr[lane];
			assign drop[lane] = clr[lane] & ~set_v[lane];

			chk_mf_align_set: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
				LANE_EVT_I[lane].lane_err[7] |=> stat[lane][LASR_BIT_MF_ALIGN])
				else $error("multiframe alignment error not latched");

			chk_fr_align_set: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
				LANE_EVT_I[lane].lane_err[6] |=> stat[lane][LASR_BIT_FR_ALIGN])
				else $error("frame alignment error not latched");

			chk_link_cfg_set: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
				LANE_EVT_I[lane].lane_err[5] |=> stat[lane][LASR_BIT_LINK_CFG])
				else $error("link configuration error not latched");

			chk_eb_ovf_set: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
				LANE_EVT_I[lane].lane_err[4] |=> stat[lane][LASR_BIT_EB_OVF])
				else $error("elastic buffer overflow not latched");

			chk_eb_match_set: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
				LANE_EVT_I[lane].lane_err[3] |=> stat[lane][LASR_BIT_EB_MATCH])
				else $error("elastic buffer match error not latched");

			chk_code_sync_set: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
				LANE_EVT_I[lane].lane_err[2] |=> stat[lane][LASR_BIT_CODE_SYNC])
				else $error("code sync error not latched");

			chk_not_table_set: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
				LANE_EVT_I[lane].lane_err[1] |=> stat[lane][LASR_BIT_NOT_TABLE])
				else $error("not-in-table error not latched");

			chk_disparity_set: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
				LANE_EVT_I[lane].lane_err[0] |=> stat[lane][LASR_BIT_DISP])
				else $error("disparity error not latched");

			chk_fifo_wr_err: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
				LANE_EVT_I[lane].fifo_wr_req && LANE_EVT_I[lane].fifo_full
				|=> stat[lane][LASR_BIT_WR_ERR] && stat[lane][LASR_BIT_FULL])
				else $error("fifo write error not latched");

			chk_fifo_wr_cause: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
				$rose(stat[lane][LASR_BIT_WR_ERR])
				|-> $past(LANE_EVT_I[lane].fifo_wr_req) && $past(LANE_EVT_I[lane].fifo_full))
				else $error("fifo write error raised without cause");

			chk_fifo_full: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
				LANE_EVT_I[lane].fifo_full |=> stat[lane][LASR_BIT_FULL])
				else $error("fifo full not shown");

			chk_fifo_rd_err: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
				LANE_EVT_I[lane].fifo_rd_req && LANE_EVT_I[lane].fifo_empty
				|=> stat[lane][LASR_BIT_RD_ERR] && stat[lane][LASR_BIT_EMPTY])
				else $error("fifo read error not latched");

			chk_fifo_rd_cause: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
				$rose(stat[lane][LASR_BIT_RD_ERR])
				|-> $past(LANE_EVT_I[lane].fifo_rd_req) && $past(LANE_EVT_I[lane].fifo_empty))
				else $error("fifo read error raised without cause");

			chk_fifo_empty: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
				LANE_EVT_I[lane].fifo_empty |=> stat[lane][LASR_BIT_EMPTY])
				else $error("fifo empty not shown");

			chk_rsv_zero: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
				stat[lane][LASR_RSV_MSB:LASR_RSV_LSB] == 4'h0)
				else $error("reserved status bits not zero");

			chk_reset_zero: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
				!$past(RST_N_I) |-> stat[lane] == LASR_STAT_RST && mask_ff[lane] == LASR_MASK_RST)
				else $error("register not zero after reset");

			chk_sticky_hold: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
				1'b1 |=> (stat[lane] & $past(keep[lane])) == $past(keep[lane]))
				else $error("status bit dropped without a clear");

			chk_clear_takes: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
				drop[lane] != 16'h0000 |=> (stat[lane] & $past(drop[lane])) == 16'h0000)
				else $error("write one did not clear status bit");

			chk_set_wins: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
				1'b1 |=> (stat[lane] & $past(set_v[lane])) == $past(set_v[lane]))
				else $error("event lost against a clear");

			chk_no_spurious: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
				1'b1 |=> (stat[lane] & ~($past(stat[lane]) | $past(set_v[lane]))) == 16'h0000)
				else $error("status bit raised without its own lane event");

			chk_lane_read: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
				rd_stat_hit[lane] |=> HRDATA_O == {16'h0000, $past(stat[lane])})
				else $error("read data not the addressed lane status");

			chk_mask_read: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
				ap_read && ap_mask_hit[lane] |=> HRDATA_O == {16'h0000, $past(mask_ff[lane])})
				else $error("read data not the addressed mask");

			// a bit may rise only one cycle after its own condition, never from a stray clear
			chk_mf_align_cause: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
				$rose(stat[lane][LASR_BIT_MF_ALIGN]) |-> $past(LANE_EVT_I[lane].lane_err[7]))
				else $error("multiframe alignment bit raised without cause");

			chk_fr_align_cause: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
				$rose(stat[lane][LASR_BIT_FR_ALIGN]) |-> $past(LANE_EVT_I[lane].lane_err[6]))
				else $error("frame alignment bit raised without cause");

			chk_link_cfg_cause: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
				$rose(stat[lane][LASR_BIT_LINK_CFG]) |-> $past(LANE_EVT_I[lane].lane_err[5]))
				else $error("link configuration bit raised without cause");

			chk_eb_ovf_cause: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
				$rose(stat[lane][LASR_BIT_EB_OVF]) |-> $past(LANE_EVT_I[lane].lane_err[4]))
				else $error("elastic buffer overflow bit raised without cause");

			chk_eb_match_cause: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
				$rose(stat[lane][LASR_BIT_EB_MATCH]) |-> $past(LANE_EVT_I[lane].lane_err[3]))
				else $error("elastic buffer match bit raised without cause");

			chk_code_sync_cause: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
				$rose(stat[lane][LASR_BIT_CODE_SYNC]) |-> $past(LANE_EVT_I[lane].lane_err[2]))
				else $error("code sync bit raised without cause");

			chk_not_table_cause: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
				$rose(stat[lane][LASR_BIT_NOT_TABLE]) |-> $past(LANE_EVT_I[lane].lane_err[1]))
				else $error("not-in-table bit raised without cause");

			chk_disparity_cause: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
				$rose(stat[lane][LASR_BIT_DISP]) |-> $past(LANE_EVT_I[lane].lane_err[0]))
				else $error("disparity bit raised without cause");

			chk_full_cause: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
				$rose(stat[lane][LASR_BIT_FULL]) |-> $past(LANE_EVT_I[lane].fifo_full))
				else $error("fifo full bit raised without cause");

			chk_empty_cause: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
				$rose(stat[lane][LASR_BIT_EMPTY]) |-> $past(LANE_EVT_I[lane].fifo_empty))
				else $error("fifo empty bit raised without cause");

			chk_full_drops: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
				wr_stat_hit[lane] && HWDATA_I[LASR_BIT_FULL] && !LANE_EVT_I[lane].fifo_full
				|=> !stat[lane][LASR_BIT_FULL])
				else $error("fifo full bit kept after clear with fifo not full");

			chk_empty_drops: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
				wr_stat_hit[lane] && HWDATA_I[LASR_BIT_EMPTY] && !LANE_EVT_I[lane].fifo_empty
				|=> !stat[lane][LASR_BIT_EMPTY])
				else $error("fifo empty bit kept after clear with fifo not empty");

			chk_read_keeps: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
				rd_stat_hit[lane] && !wr_stat_hit[lane]
				|=> (stat[lane] & $past(stat[lane])) == $past(stat[lane]))
				else $error("status read cleared a bit");

			chk_zero_wr_keeps: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
				wr_stat_hit[lane] && HWDATA_I[15:0] == 16'h0000
				|=> stat[lane] == ($past(stat[lane]) | $past(set_v[lane])))
				else $error("zero write changed a status bit");

			chk_other_wr_keeps: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
				wr_pend_ff && wr_idx_ff != LASR_IDX_LANE3 + 10'(lane)
				|=> (stat[lane] & $past(stat[lane])) == $past(stat[lane]))
				else $error("write to another address cleared this lane");

			chk_mask_load: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
				wr_mask_hit[lane] |=> mask_ff[lane] == $past(HWDATA_I[15:0]))
				else $error("mask write not applied");

			chk_mask_hold: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
				!wr_mask_hit[lane] |=> $stable(mask_ff[lane]))
				else $error("mask changed without a write");
		end
	endgenerate

	// read data are a snapshot taken at the address phase; unmapped words read zero
	always_comb begin
		nxt_hrdata = LASR_RDATA_RST;
		for (int i = 0; i < LASR_NUM_LANES; i++) begin
			if (ap_stat_hit[i]) begin
				nxt_hrdata = {16'h0000, stat[i]};
			end
			if (ap_mask_hit[i]) begin
				nxt_hrdata = {16'h0000, mask_ff[i]};
			end
		end
	end

	always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			hrdata_ff <= LASR_RDATA_RST;
		end else if (ap_read) begin
			hrdata_ff <= nxt_hrdata;
		end
	end

	assign HRDATA_O = hrdata_ff;

	// registered so the interrupt line never glitches on a clear
	always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= |lane_irq;
		end
	end

	assign IRQ_O = irq_ff;

	chk_irq_level: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
		|lane_irq |=> IRQ_O)
		else $error("interrupt not raised for unmasked status");

	chk_irq_quiet: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
		!(|lane_irq) |=> !IRQ_O)
		else $error("interrupt raised with nothing unmasked");

	chk_unmapped_zero: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
		ap_read && !(|ap_stat_hit) && !(|ap_mask_hit) |=> HRDATA_O == LASR_RDATA_RST)
		else $error("unmapped read not zero");

	chk_bus_okay: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
		HREADYOUT_O && HRESP_O == LASR_HRESP_OKAY)
		else $error("slave stalled or answered with an error");

	chk_reset_outputs: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
		!$past(RST_N_I) |-> HRDATA_O == LASR_RDATA_RST && !IRQ_O)
		else $error("read data or interrupt not zero after reset");

	chk_read_hold: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
		!ap_read |=> $stable(HRDATA_O))
		else $error("read data changed without a read");

	chk_rdata_upper: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
		HRDATA_O[31:16] == 16'h0000)
		else $error("upper read data bits not zero");

endmodule // lasr_regs

// ===== tb/lasr_lane_src.sv
`timescale 1ns/100ps
module lasr_lane_src
	import lasr_pkg::*;
#(
	parameter int DLY = 1
)
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire lasr_lane_evt_t [2:0] want_i,
	output lasr_lane_evt_t [2:0] evt_o
);
	// lane conditions reach the core DLY cycles late, like a slow receive path
	lasr_lane_evt_t [2:0] pipe_ff [DLY];

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			for (int i = 0; i < DLY; i++) begin
				pipe_ff[i] <= '0;
			end
		end else begin
			pipe_ff[0] <= want_i;
			for (int i = 1; i < DLY; i++) begin
				pipe_ff[i] <= pipe_ff[i - 1];
			end
		end
	end

	assign evt_o = pipe_ff[DLY - 1];
endmodule // lasr_lane_src

// ===== tb/test_lasr_regs.sv
`timescale 1ns/100ps
module test_lasr_regs
	import lasr_pkg::*;
;
	logic clk, rst_n, hsel, hwrite, hrdy, hresp, irq;
	logic [11:0] haddr;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] hwdata, hrdata;
	lasr_lane_evt_t [2:0] want, evt;
	int n_errors, checks_done;

	lasr_regs u_lasr_regs (.CORE_CLK_I(clk), .RST_N_I(rst_n), .HSEL_I(hsel), .HADDR_I(haddr),
		.HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(hsize), .HWDATA_I(hwdata),
		.HREADY_I(hrdy), .HREADYOUT_O(hrdy), .HRESP_O(hresp), .HRDATA_O(hrdata),
		.LANE_EVT_I(evt), .IRQ_O(irq));
	lasr_lane_src #(.DLY(2)) u_lasr_lane_src (.clk_i(clk), .rst_n_i(rst_n), .want_i(want),
		.evt_o(evt));

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// the bus has one slave, so hready is its own ready; bounded so a stuck bus ends the run
	task automatic wait_rdy();
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (hrdy !== 1'b1 && n < 50);
		if (hrdy !== 1'b1) begin
			n_errors++;
			end_of_test();
		end
	endtask

	task automatic xfer(input logic [9:0] idx, input logic wr, input logic [31:0] wd,
		output logic [31:0] rdat);
		@(posedge clk);
		htrans <= LASR_HTRANS_NONSEQ;
		haddr <= {idx, 2'b00};
		hwrite <= wr;
		wait_rdy();
		htrans <= LASR_HTRANS_IDLE;
		hwdata <= wd;
		wait_rdy();
		rdat = hrdata;
	endtask

	task automatic rd_chk(input string what, input logic [9:0] idx, input logic [31:0] exp);
		logic [31:0] d;
		xfer(idx, 1'b0, 32'h0000_0000, d);
		check(what, d, exp);
		check("hresp", 32'(hresp), 32'(LASR_HRESP_OKAY));
	endtask

	task automatic wr(input logic [9:0] idx, input logic [31:0] wd);
		logic [31:0] d;
		xfer(idx, 1'b1, wd, d);
	endtask

	// hold sets the conditions that stay present after the one-cycle pulse of e
	task automatic raise(input int ln, input lasr_lane_evt_t e, input lasr_lane_evt_t hold);
		@(posedge clk);
		want[ln] <= e;
		@(posedge clk);
		want[ln] <= hold;
		repeat (4) @(posedge clk);
	endtask

	task automatic t_reset();
		for (int r = 0; r < 3; r++) begin
			rd_chk("status after reset", LASR_IDX_LANE3 + 10'(r), 32'h0000_0000);
			rd_chk("mask after reset", LASR_IDX_MASK_BASE + 10'(r), 32'h0000_0000);
		end
		wr(10'h06A, 32'h0000_FFFF);
		rd_chk("unmapped", 10'h06A, 32'h0000_0000);
		$display("test reset done");
	endtask

	task automatic t_bits();
		lasr_lane_evt_t e;
		for (int ln = 0; ln < 3; ln++) begin
			for (int b = 0; b < 8; b++) begin
				e = '0;
				e.lane_err[b] = 1'b1;
				raise(ln, e, '0);
				for (int r = 0; r < 3; r++) begin
					rd_chk("lane status", LASR_IDX_LANE3 + 10'(r),
						(r == ln) ? 32'h0000_0001 << (8 + b) : 32'h0000_0000);
				end
				wr(LASR_IDX_LANE3 + 10'(ln), 32'h0000_0001 << (8 + b));
				rd_chk("cleared", LASR_IDX_LANE3 + 10'(ln), 32'h0000_0000);
			end
		end
		$display("test error bits done");
	endtask

	task automatic t_fifo();
		lasr_lane_evt_t e, h;
		e = '0;
		h = '0;
		h.fifo_full = 1'b1;
		e.fifo_full = 1'b1;
		e.fifo_wr_req = 1'b1;
		raise(1, e, h);
		rd_chk("full and write", LASR_IDX_LANE4, 32'h0000_000C);
		wr(LASR_IDX_LANE4, 32'h0000_0000);
		rd_chk("zero write", LASR_IDX_LANE4, 32'h0000_000C);
		wr(LASR_IDX_LANE4, 32'h0000_000F);
		rd_chk("still full", LASR_IDX_LANE4, 32'h0000_0004);
		e = '0;
		e.fifo_wr_req = 1'b1;
		e.fifo_rd_req = 1'b1;
		raise(1, e, '0);
		wr(LASR_IDX_LANE4, 32'h0000_000F);
		rd_chk("requests alone", LASR_IDX_LANE4, 32'h0000_0000);
		e.fifo_empty = 1'b1;
		raise(1, e, '0);
		rd_chk("empty and read", LASR_IDX_LANE4, 32'h0000_0003);
		wr(LASR_IDX_LANE4, 32'h0000_0003);
		raise(2, '1, '0);
		rd_chk("all set", LASR_IDX_LANE5, 32'h0000_FF0F);
		wr(LASR_IDX_LANE5, 32'h0000_FFFF);
		rd_chk("all cleared", LASR_IDX_LANE5, 32'h0000_0000);
		$display("test fifo flags done");
	endtask

	task automatic t_irq();
		lasr_lane_evt_t e;
		e = '0;
		e.lane_err[7] = 1'b1;
		wr(LASR_IDX_MASK_BASE + 10'h001, 32'h0000_8000);
		rd_chk("mask", LASR_IDX_MASK_BASE + 10'h001, 32'h0000_8000);
		raise(0, e, '0);
		@(negedge clk);
		check("irq masked", 32'(irq), 32'h0000_0000);
		raise(1, e, '0);
		@(negedge clk);
		check("irq raised", 32'(irq), 32'h0000_0001);
		wr(LASR_IDX_LANE4, 32'h0000_8000);
		repeat (3) @(negedge clk);
		check("irq cleared", 32'(irq), 32'h0000_0000);
		wr(LASR_IDX_LANE3, 32'h0000_8000);
		$display("test interrupt done");
	endtask

	initial begin
		rst_n = 1'b0;
		hsel = 1'b1;
		hwrite = 1'b0;
		haddr = 12'h000;
		htrans = LASR_HTRANS_IDLE;
		hsize = 3'h2;
		hwdata = 32'h0000_0000;
		want = '0;
		n_errors = 0;
		checks_done = 0;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_bits();
		t_fifo();
		t_irq();
		end_of_test();
	end
endmodule // test_lasr_regs
